// *** hw/tx_clock_select_pkg.sv ***
// Package: register map, field layout, reset values and carrier types for tx clock select
package tx_clock_select_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [1:0] addr_tx_clock_select = 2'h0;
  localparam logic [1:0] addr_irq_status = 2'h1;
  localparam logic [1:0] addr_irq_mask = 2'h2;
  localparam logic [1:0] addr_live_status = 2'h3;

  // ----------------------------------------------------------------
  // Field positions of tx_clock_select
  // ----------------------------------------------------------------
  localparam int pos_violation_inject = 7;
  localparam int pos_standard_select = 6;
  localparam int pos_align_tick = 5;
  localparam int pos_fallback_enable = 4;
  localparam int pos_source_hi = 1;
  localparam int pos_source_lo = 0;

  // Reset value: fallback enable set, source select 01
  localparam logic [7:0] tx_clock_select_reset = 8'h11;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int irq_clock_loss = 0;
  localparam int irq_clock_regain = 1;
  localparam int irq_width = 2;

  localparam logic [1:0] source_loop_a = 2'h0;
  localparam logic [1:0] source_external = 2'h1;
  localparam logic [1:0] source_pll = 2'h2;
  localparam logic [1:0] source_loop_b = 2'h3;

  typedef enum logic [1:0] {
    timing_loop = 2'h0,
    timing_external = 2'h1,
    timing_pll = 2'h3
  } timing_type;

  // Control fields steering the framer and line interface
  typedef struct packed {
    logic standard_t1;
    logic align_tick;
    logic fallback_enable;
    logic [1:0] source_select;
  } control_type;

  typedef struct packed {
    logic [1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } bus_request_type;

endpackage

// *** hw/edge_pulse.sv ***
// Module: rising-edge detector giving a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

module edge_pulse
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic level,
  output logic pulse
);

  logic level_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_reg <= 1'b0;
    end
    else
    begin
      level_reg <= level;
    end
  end

  assign pulse = level & ~level_reg;

endmodule

`default_nettype wire

// *** hw/sync_two_flop.sv ***
// Module: two-flip-flop synchroniser for a level from another domain
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);

  logic first_reg;
  logic second_reg;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      first_reg <= 1'b0;
      second_reg <= 1'b0;
    end
    else
    begin
      first_reg <= async_in;
      second_reg <= first_reg;
    end
  end

  assign sync_out = second_reg;

endmodule

`default_nettype wire

// *** hw/tx_clock_select_control.sv ***
// Module: per-channel transmit clock select and mode control with Avalon-MM registers
//
// Contract
// [R1]: A zero-to-one write of the inject bit sends exactly one line code violation pulse.
// [R2]: The standard select bit chooses E1 when zero and T1 when one, resetting to zero.
// [R3]: The align bit makes the framer align frames to the PLL 8 kHz tick, resetting to zero.
// [R4]: Tick alignment applies only while the master PLL is the chosen timing source.
// [R5]: With fallback enabled and loop timing chosen, loss of recovery switches to the PLL.
// [R6]: After fallback the PLL stays in use until recovery returns, then loop timing resumes.
// [R7]: The fallback enable bit turns clock loss protection off at zero, on at one, reset one.
// [R8]: The clock loss status bit is raised only while the fallback enable is set.
// [R9]: Source codes 00 and 11 pick loop, 01 external, 10 PLL; the field resets to 01.
// [R10]: The serial clock pin is an input for external timing, an output otherwise.
// [R11]: Reserved bits three and two are read-write, reset zero and steer nothing.
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module tx_clock_select_control
(
  input wire logic core_clk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Line interface and PLL status, asynchronous
  input wire logic clock_recovery_lost,
  input wire logic pll_tick,
  // Framer and line interface controls
  output logic line_violation_inject,
  output logic channel_standard_select,
  output logic frame_align_to_pll_tick,
  output logic [1:0] tx_timing_active,
  output logic tx_serial_clock_oe_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic lost_sync;
  logic tick_sync;
  logic tick_pulse;
  logic inject_pulse;

  sync_two_flop lost_sync_inst
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(clock_recovery_lost),
    .sync_out(lost_sync)
  );

  sync_two_flop tick_sync_inst
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(pll_tick),
    .sync_out(tick_sync)
  );

  edge_pulse tick_edge_inst
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .level(tick_sync),
    .pulse(tick_pulse)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int irq_w_hi = tx_clock_select_pkg::irq_width - 1;
  tx_clock_select_pkg::bus_request_type req;
  logic [7:0] tx_clock_select_reg;
  logic [irq_w_hi:0] irq_status_reg;
  logic [tx_clock_select_pkg::irq_width-1:0] irq_mask_reg;
  logic [tx_clock_select_pkg::irq_width-1:0] irq_set;
  logic bus_done_reg;
  logic access;
  logic wr_fire;
  logic sel_write;
  logic fallback_reg;

  assign req.address = avs_address;
  assign req.read = avs_read;
  assign req.write = avs_write;
  assign req.writedata = avs_writedata;
  assign access = (req.read | req.write) & ~bus_done_reg;
  // Writes commit only at the edge where the master sees waitrequest low
  assign wr_fire = req.write & ~avs_waitrequest & avs_byteenable[0];
  assign sel_write = wr_fire & (req.address == tx_clock_select_pkg::addr_tx_clock_select);

  // One wait cycle per access: waitrequest drops the cycle after the request appears
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_done_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      bus_done_reg <= access;
      avs_waitrequest <= ~access;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_clock_select_reg <= tx_clock_select_pkg::tx_clock_select_reset; // [R2] [R7] [R9] [R11]
    end
    else if (sel_write)
    begin
      tx_clock_select_reg <= req.writedata[7:0]; // [R11]
    end
  end

  // Inject fires on the written zero-to-one change only
  assign inject_pulse = sel_write & req.writedata[tx_clock_select_pkg::pos_violation_inject]
    & ~tx_clock_select_reg[tx_clock_select_pkg::pos_violation_inject]; // [R1]

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_mask_reg <= '0;
    end
    else if (wr_fire && req.address == tx_clock_select_pkg::addr_irq_mask)
    begin
      irq_mask_reg <= req.writedata[tx_clock_select_pkg::irq_width-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (req.read && !bus_done_reg)
    begin
      unique case (req.address)
        tx_clock_select_pkg::addr_tx_clock_select:
          avs_readdata <= {24'h000000, tx_clock_select_reg};
        tx_clock_select_pkg::addr_irq_status:
          avs_readdata <= {30'h00000000, irq_status_reg};
        tx_clock_select_pkg::addr_irq_mask:
          avs_readdata <= {30'h00000000, irq_mask_reg};
        tx_clock_select_pkg::addr_live_status:
          avs_readdata <= {27'h0000000, fallback_reg, tx_timing_active, frame_align_to_pll_tick,
            lost_sync};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timing source and fallback
  // ----------------------------------------------------------------
  tx_clock_select_pkg::control_type ctrl;
  logic loop_chosen;
  logic pll_chosen;
  logic fallback_next;

  assign ctrl.standard_t1 = tx_clock_select_reg[tx_clock_select_pkg::pos_standard_select];
  assign ctrl.align_tick = tx_clock_select_reg[tx_clock_select_pkg::pos_align_tick];
  assign ctrl.fallback_enable = tx_clock_select_reg[tx_clock_select_pkg::pos_fallback_enable];
  assign ctrl.source_select = tx_clock_select_reg[tx_clock_select_pkg::pos_source_hi:
    tx_clock_select_pkg::pos_source_lo];

  assign loop_chosen = (ctrl.source_select == tx_clock_select_pkg::source_loop_a)
    | (ctrl.source_select == tx_clock_select_pkg::source_loop_b); // [R9]
  assign pll_chosen = ctrl.source_select == tx_clock_select_pkg::source_pll; // [R9]
  assign fallback_next = ctrl.fallback_enable & loop_chosen & lost_sync; // [R5] [R6] [R7]

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fallback_reg <= 1'b0;
    end
    else
    begin
      fallback_reg <= fallback_next; // [R5] [R6]
    end
  end

  // Events: clock loss and regain, only reported with protection on
  always_comb
  begin
    irq_set = '0;
    irq_set[tx_clock_select_pkg::irq_clock_loss] = fallback_next & ~fallback_reg; // [R8]
    irq_set[tx_clock_select_pkg::irq_clock_regain] = ~fallback_next & fallback_reg
      & ctrl.fallback_enable & loop_chosen;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < tx_clock_select_pkg::irq_width; i++)
      begin
        if (irq_set[i])
        begin
          irq_status_reg[i] <= 1'b1;
        end
        else if (wr_fire && req.address == tx_clock_select_pkg::addr_irq_status
          && req.writedata[i])
        begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      line_violation_inject <= 1'b0;
      channel_standard_select <= 1'b0;
      frame_align_to_pll_tick <= 1'b0;
      tx_timing_active <= tx_clock_select_pkg::timing_external;
      tx_serial_clock_oe_n <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      line_violation_inject <= inject_pulse; // [R1]
      channel_standard_select <= ctrl.standard_t1; // [R2]
      frame_align_to_pll_tick <= ctrl.align_tick & pll_chosen & tick_pulse; // [R3] [R4]
      if (pll_chosen || fallback_next)
      begin
        tx_timing_active <= tx_clock_select_pkg::timing_pll; // [R5]
      end
      else if (loop_chosen)
      begin
        tx_timing_active <= tx_clock_select_pkg::timing_loop; // [R6]
      end
      else
      begin
        tx_timing_active <= tx_clock_select_pkg::timing_external;
      end
      // Oe low means the pin is driven
      tx_serial_clock_oe_n <= ~(loop_chosen | pll_chosen); // [R10]
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_inject_single: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    line_violation_inject |=> !line_violation_inject)
    else $error("violation inject lasted more than one cycle");

  a_inject_edge: assert property (@(posedge core_clk) disable iff (!resetn) // [R1]
    line_violation_inject |-> tx_clock_select_reg[7] && !$past(tx_clock_select_reg[7]))
    else $error("violation inject without a zero to one change");

  a_standard_follow: assert property (@(posedge core_clk) disable iff (!resetn) // [R2]
    ##1 channel_standard_select == $past(tx_clock_select_reg[6]))
    else $error("standard select output does not follow register");

  a_align_only_pll: assert property (@(posedge core_clk) disable iff (!resetn) // [R4]
    frame_align_to_pll_tick |-> $past(tx_clock_select_reg[1:0]) == 2'h2)
    else $error("tick alignment outside PLL timing");

  a_align_needs_bit: assert property (@(posedge core_clk) disable iff (!resetn) // [R3]
    frame_align_to_pll_tick |-> $past(tx_clock_select_reg[5]))
    else $error("tick alignment with align bit clear");

  a_fallback_pll: assert property (@(posedge core_clk) disable iff (!resetn) // [R5]
    fallback_reg |-> tx_timing_active == tx_clock_select_pkg::timing_pll)
    else $error("fallback active but PLL not in use");

  a_fallback_return: assert property (@(posedge core_clk) disable iff (!resetn) // [R6]
    fallback_reg && !lost_sync && loop_chosen |=>
    tx_timing_active == tx_clock_select_pkg::timing_loop)
    else $error("loop timing not restored after recovery");

  a_loss_gated: assert property (@(posedge core_clk) disable iff (!resetn) // [R8]
    $rose(irq_status_reg[0]) |-> $past(ctrl.fallback_enable))
    else $error("clock loss status raised with protection off");

  a_pin_dir: assert property (@(posedge core_clk) disable iff (!resetn) // [R10]
    ##1 tx_serial_clock_oe_n == ($past(ctrl.source_select) == 2'h1))
    else $error("serial clock pin direction wrong");

endmodule

`default_nettype wire

// *** tb/far_side_model.sv ***
// Far-side model: line interface recovery status, free-running PLL tick, pulse counters
`timescale 1ns/1ps
`default_nettype none

module far_side_model
#(
  parameter int tick_half = 20
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic loss_request,
  input wire logic line_violation_inject,
  input wire logic frame_align_to_pll_tick,
  output logic clock_recovery_lost,
  output logic pll_tick,
  output int violation_count,
  output int align_count
);
  int phase;

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  // The PLL tick runs free; it does not stop between frames
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      phase <= 0;
      pll_tick <= 1'b0;
    end
    else if (phase == tick_half - 1)
    begin
      phase <= 0;
      pll_tick <= !pll_tick;
    end
    else
      phase <= phase + 1;

  // ----------------------------------------------------------------
  // Recovery status and counters
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      clock_recovery_lost <= 1'b0;
      violation_count <= 0;
      align_count <= 0;
    end
    else
    begin
      clock_recovery_lost <= loss_request;
      violation_count <= violation_count + int'(line_violation_inject);
      align_count <= align_count + int'(frame_align_to_pll_tick);
    end
endmodule

`default_nettype wire

// *** tb/tx_clock_select_control_test.sv ***
// Testbench: register, timing source, injection, alignment and fallback checks
`timescale 1ns/1ps
`default_nettype none

module tx_clock_select_control_test;
  localparam logic [1:0] a_sel = tx_clock_select_pkg::addr_tx_clock_select;
  localparam logic [1:0] a_sts = tx_clock_select_pkg::addr_irq_status;
  localparam logic [1:0] a_msk = tx_clock_select_pkg::addr_irq_mask;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic loss_request = 1'b0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic avs_waitrequest, line_violation_inject, channel_standard_select;
  logic frame_align_to_pll_tick, tx_serial_clock_oe_n, irq, clock_recovery_lost, pll_tick;
  logic [1:0] tx_timing_active;
  logic [7:0] d;
  logic [7:0] align_cases [4] = '{8'h32, 8'h31, 8'h12, 8'h30};
  int violation_count, align_count, fails, checked, n, mark, seed;

  initial
  begin
    forever #4 core_clk = !core_clk;
  end

  tx_clock_select_control u_tx_clock_select_control (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clock_recovery_lost(clock_recovery_lost), .pll_tick(pll_tick),
    .line_violation_inject(line_violation_inject),
    .channel_standard_select(channel_standard_select),
    .frame_align_to_pll_tick(frame_align_to_pll_tick), .tx_timing_active(tx_timing_active),
    .tx_serial_clock_oe_n(tx_serial_clock_oe_n), .irq(irq));

  far_side_model u_far_side_model (.core_clk(core_clk), .resetn(resetn),
    .loss_request(loss_request), .line_violation_inject(line_violation_inject),
    .frame_align_to_pll_tick(frame_align_to_pll_tick),
    .clock_recovery_lost(clock_recovery_lost), .pll_tick(pll_tick),
    .violation_count(violation_count), .align_count(align_count));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request holds until waitrequest is sampled low; read data taken at that edge
  task bus(input logic wr, input logic [1:0] a, input logic [7:0] wd, input logic [3:0] be);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, wd};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check("wait cycles", 32'(k), 32'h2);
  endtask

  task wait_timing(input logic [1:0] t);
    for (int k = 0; k < 40 && tx_timing_active !== t; k++)
      @(posedge core_clk);
  endtask

  function automatic logic [31:0] timing_exp(input logic [1:0] code);
    if (code == tx_clock_select_pkg::source_pll)
      return 32'h3;
    return (code == tx_clock_select_pkg::source_external) ? 32'h1 : 32'h0;
  endfunction

  task end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 40;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    check("timing reset", 32'(tx_timing_active), 32'h1);
    check("oe_n reset", 32'(tx_serial_clock_oe_n), 32'h1);
    bus(1'b0, a_sel, 8'h00, 4'hF);
    check("select reset", rd, 32'h11);
    $display("test reset done");
    // Every source code first, then random fields including reserved bits
    for (n = 0; n < 12; n++)
    begin
      d = 8'($random(seed));
      if (n < 4)
        d[1:0] = n[1:0];
      bus(1'b1, a_sel, d, 4'hF);
      bus(1'b0, a_sel, 8'h00, 4'hF);
      check("select readback", rd, {24'h000000, d});
      repeat (8) @(posedge core_clk);
      check("standard", 32'(channel_standard_select), 32'(d[6]));
      check("timing", 32'(tx_timing_active), timing_exp(d[1:0]));
      check("oe_n", 32'(tx_serial_clock_oe_n), 32'(d[1:0] == 2'h1));
    end
    bus(1'b1, a_sel, ~d, 4'hE);
    bus(1'b0, a_sel, 8'h00, 4'hF);
    check("lane 0 off", rd, {24'h000000, d});
    $display("test fields done");
    bus(1'b1, a_sel, 8'h11, 4'hF);
    repeat (4) @(posedge core_clk);
    mark = violation_count;
    bus(1'b1, a_sel, 8'h91, 4'hF);
    bus(1'b1, a_sel, 8'h91, 4'hF);
    repeat (8) @(posedge core_clk);
    check("violations", 32'(violation_count - mark), 32'h1);
    $display("test inject done");
    // Only PLL timing with the align bit may align frames
    for (n = 0; n < 4; n++)
    begin
      bus(1'b1, a_sel, align_cases[n], 4'hF);
      repeat (8) @(posedge core_clk);
      mark = align_count;
      repeat (200) @(posedge core_clk);
      check("align", 32'(align_count != mark), 32'(n == 0));
    end
    $display("test align done");
    bus(1'b1, a_msk, 8'h01, 4'hF);
    bus(1'b1, a_sel, 8'h10, 4'hF);
    bus(1'b1, a_sts, 8'h03, 4'hF);
    loss_request <= 1'b1;
    wait_timing(2'h3);
    check("fallback", 32'(tx_timing_active), 32'h3);
    repeat (3) @(posedge core_clk);
    check("irq on", 32'(irq), 32'h1);
    loss_request <= 1'b0;
    wait_timing(2'h0);
    check("return", 32'(tx_timing_active), 32'h0);
    bus(1'b0, a_sts, 8'h00, 4'hF);
    check("loss and regain", rd, 32'h3);
    bus(1'b1, a_sts, 8'h03, 4'hF);
    repeat (3) @(posedge core_clk);
    check("irq cleared", 32'(irq), 32'h0);
    bus(1'b1, a_sel, 8'h00, 4'hF);
    loss_request <= 1'b1;
    repeat (40) @(posedge core_clk);
    check("no fallback", 32'(tx_timing_active), 32'h0);
    bus(1'b0, a_sts, 8'h00, 4'hF);
    check("no loss status", 32'(rd[0]), 32'h0);
    loss_request <= 1'b0;
    bus(1'b1, a_msk, 8'h00, 4'hF);
    bus(1'b1, a_sel, 8'h10, 4'hF);
    repeat (10) @(posedge core_clk);
    loss_request <= 1'b1;
    wait_timing(2'h3);
    repeat (4) @(posedge core_clk);
    check("masked irq", 32'(irq), 32'h0);
    bus(1'b0, tx_clock_select_pkg::addr_live_status, 8'h00, 4'hF);
    check("live status", rd, 32'h1D);
    bus(1'b0, a_sts, 8'h00, 4'hF);
    check("loss status", 32'(rd[0]), 32'h1);
    $display("test fallback done");
    end_of_test();
  end
endmodule

`default_nettype wire
